//--- rtl/dpcfg_regs.sv
// Purpose: Configuration and status registers of a dual-channel datapath
// Assumes: Serial port decoder drives the register port on clock_i
// Notes: Also conditions input samples and flags input power excess
// Contract
// - Writing 1 to FIFO control bit 0 requests an input FIFO reset.
// - Read-only FIFO control bit 1 reports the requested reset done.
// - Format bit 7: 0 twos complement, 1 offset binary converted first.
// - Format bit 6: pair I with next Q (0) or prior Q (1).
// - Format bit 5 reverses input bus bit order.
// - Format bit 0: 0 word interface, 1 byte interface.
// - Datapath bits 7, 6, 2 enable droop filter, oscillator, quarter mixer.
// - Datapath bit 5 enables gain and offset, bit 4 phase correction.
// - Datapath bit 1 picks high (0) or low (1) image.
// - Datapath bit 0 sends I to both channels; Q path still runs.
// - Rate field 00 is 2x, 10 is 4x, 11 is 8x half-band stages.
// - Threshold is low byte plus five upper bits of mean power.
// - Guard bit 7 enables protection; disabled means never triggered.
// - Guard bit 6 swaps I and Q inside the power computation.
// - Window field sets pairs averaged: 512 up to 2^19; above invalid.
// - Mean power low eight bits read at 0x2c.
// - Mean power upper five bits read at 0x2d, 13 bits total.
`timescale 1ns/1ps
`include "dpcfg_cfg.svh"
module dpcfg_regs #(
   parameter int WIN_BASE_LOG2 = `DPCFG_WIN_BASE_LOG2
) (
   input wire logic clock_i,
   input wire logic arst_n_i,
   input wire logic ce_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   output logic fifo_reset_o,
   input wire logic fifo_reset_done_i,
   input wire logic [15:0] sample_i,
   input wire logic sample_valid_i,
   output logic [15:0] chan_i_o,
   output logic [15:0] chan_q_o,
   output logic chan_valid_o,
   output logic droop_corrector_on_o,
   output logic numeric_oscillator_on_o,
   output logic gain_offset_correct_on_o,
   output logic phase_correct_on_o,
   output logic quarter_rate_mixer_on_o,
   output logic image_side_select_o,
   output logic halfband_stage_one_o,
   output logic halfband_stage_two_o,
   output logic halfband_stage_three_o,
   output logic rate_reserved_o,
   output logic protect_o
);
   dpcfg_pkg::dpcfg_hs_t hs_reg;
   dpcfg_pkg::dpcfg_hs_t hs_next;
   logic fifo_req_reg;
   logic [7:0] fmt_reg;
   logic [7:0] path_reg;
   logic [7:0] interp_reg;
   logic [7:0] lim_lo_reg;
   logic [7:0] lim_hi_reg;
   logic [7:0] guard_reg;
   logic [12:0] power_w;
   logic [4:0] power_hi_w;
   logic [12:0] limit_w;
   logic [15:0] bus_w;
   logic byte_phase_reg;
   logic [7:0] byte_hi_reg;
   logic [15:0] word_reg;
   logic word_valid_reg;
   logic iq_phase_reg;
   logic [15:0] i_hold_reg;
   logic [15:0] q_hold_reg;
   logic q_seen_reg;
   logic pair_fire_w;
   logic [15:0] pair_i_w;
   logic [15:0] pair_q_w;
   logic [15:0] pwr_i_reg;
   logic [15:0] pwr_q_reg;
   logic pwr_valid_reg;
   logic ack_w;
   dpcfg_pkg::dpcfg_interp_t rate_w;

   // Reverses the order of the bits of an input bus word
   function automatic logic [15:0] dpcfg_reverse(input logic [15:0] d);
      logic [15:0] r;
      r = 16'h0000;
      for (int k = 0; k < 16; k++) begin
         r[k] = d[15-k];
      end
      return r;
   endfunction

   // Software writes land in the writable bits only
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         fifo_req_reg <= 1'(`DPCFG_R_FIFO);
         fmt_reg <= `DPCFG_R_FMT;
         path_reg <= `DPCFG_R_PATH;
         interp_reg <= `DPCFG_R_INTERP;
         lim_lo_reg <= `DPCFG_R_LIM_LO;
         lim_hi_reg <= `DPCFG_R_LIM_HI;
         guard_reg <= `DPCFG_R_GUARD;
      end else if (ce_i && reg_wr_i) begin
         case (reg_addr_i)
            `DPCFG_A_FIFO: fifo_req_reg <= reg_wdata_i[`DPCFG_B_REQ];
            `DPCFG_A_FMT: fmt_reg <= reg_wdata_i & `DPCFG_M_FMT;
            `DPCFG_A_PATH: path_reg <= reg_wdata_i & `DPCFG_M_PATH;
            `DPCFG_A_INTERP: interp_reg <= reg_wdata_i & `DPCFG_M_INTERP;
            `DPCFG_A_LIM_LO: lim_lo_reg <= reg_wdata_i;
            `DPCFG_A_LIM_HI: begin
               lim_hi_reg <= reg_wdata_i & `DPCFG_M_LIM_HI;
            end
            `DPCFG_A_GUARD: guard_reg <= reg_wdata_i & `DPCFG_M_GUARD;
            default: fifo_req_reg <= fifo_req_reg;
         endcase
      end
   end

   // Four-phase FIFO reset handshake
   always_comb begin
      hs_next = hs_reg;
      case (hs_reg)
         dpcfg_pkg::DPCFG_IDLE: begin
            if (fifo_req_reg) begin
               hs_next = dpcfg_pkg::DPCFG_RESET;
            end
         end
         dpcfg_pkg::DPCFG_RESET: begin
            if (fifo_reset_done_i) begin
               hs_next = dpcfg_pkg::DPCFG_ACK;
            end
         end
         dpcfg_pkg::DPCFG_ACK: begin
            if (!fifo_req_reg) begin
               hs_next = dpcfg_pkg::DPCFG_IDLE;
            end
         end
         default: begin
            hs_next = dpcfg_pkg::DPCFG_IDLE;
         end
      endcase
   end

   // Handshake state register
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         hs_reg <= dpcfg_pkg::DPCFG_IDLE;
      end else if (ce_i) begin
         hs_reg <= hs_next;
      end
   end

   assign fifo_reset_o = (hs_reg == dpcfg_pkg::DPCFG_RESET);
   assign ack_w = (hs_reg == dpcfg_pkg::DPCFG_ACK);

   // Stage enables straight from the datapath register
   assign droop_corrector_on_o = path_reg[`DPCFG_B_DROOP];
   assign numeric_oscillator_on_o = path_reg[`DPCFG_B_NCO];
   assign quarter_rate_mixer_on_o = path_reg[`DPCFG_B_QMIX];
   assign gain_offset_correct_on_o = path_reg[`DPCFG_B_GAIN];
   assign phase_correct_on_o = path_reg[`DPCFG_B_PHASE];
   assign image_side_select_o = path_reg[`DPCFG_B_SIDE];

   // Rate decode; the reserved code runs the first stage only
   assign rate_w = dpcfg_pkg::dpcfg_interp_t'(interp_reg[1:0]);
   assign halfband_stage_one_o = 1'b1;
   assign halfband_stage_two_o = (rate_w == dpcfg_pkg::DPCFG_X4) ||
                                 (rate_w == dpcfg_pkg::DPCFG_X8);
   assign halfband_stage_three_o = (rate_w == dpcfg_pkg::DPCFG_X8);
   assign rate_reserved_o = (rate_w == dpcfg_pkg::DPCFG_XRSV);

   // Input bus in pin order or reversed
   assign bus_w = fmt_reg[`DPCFG_B_REV] ? dpcfg_reverse(sample_i)
                                        : sample_i;

   // Word assembly: byte mode takes high byte first on the low lane
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         byte_phase_reg <= 1'b0;
         byte_hi_reg <= 8'h00;
         word_reg <= 16'h0000;
         word_valid_reg <= 1'b0;
      end else if (ce_i) begin
         word_valid_reg <= 1'b0;
         if (fifo_reset_o) begin
            byte_phase_reg <= 1'b0;
         end else if (sample_valid_i) begin
            if (!fmt_reg[`DPCFG_B_BYTE]) begin
               word_reg <= bus_w ^ {fmt_reg[`DPCFG_B_BIN], 15'h0000};
               word_valid_reg <= 1'b1;
            end else if (!byte_phase_reg) begin
               byte_hi_reg <= bus_w[7:0];
               byte_phase_reg <= 1'b1;
            end else begin
               word_reg <= {byte_hi_reg, bus_w[7:0]} ^
                           {fmt_reg[`DPCFG_B_BIN], 15'h0000};
               word_valid_reg <= 1'b1;
               byte_phase_reg <= 1'b0;
            end
         end
      end
   end

   // Pair selection: next Q holds I, prior Q is held for the next I
   assign pair_fire_w = word_valid_reg &&
      (fmt_reg[`DPCFG_B_PAIR] ? (!iq_phase_reg && q_seen_reg)
                              : iq_phase_reg);
   assign pair_i_w = fmt_reg[`DPCFG_B_PAIR] ? word_reg : i_hold_reg;
   assign pair_q_w = fmt_reg[`DPCFG_B_PAIR] ? q_hold_reg : word_reg;

   // Stream alternates I then Q, restarted by a FIFO reset
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         iq_phase_reg <= 1'b0;
         i_hold_reg <= 16'h0000;
         q_hold_reg <= 16'h0000;
         q_seen_reg <= 1'b0;
      end else if (ce_i) begin
         if (fifo_reset_o) begin
            iq_phase_reg <= 1'b0;
            q_seen_reg <= 1'b0;
         end else if (word_valid_reg) begin
            iq_phase_reg <= !iq_phase_reg;
            if (!iq_phase_reg) begin
               i_hold_reg <= word_reg;
            end else begin
               q_hold_reg <= word_reg;
               q_seen_reg <= 1'b1;
            end
         end
      end
   end

   // Channel outputs; the power path always sees the real Q
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         chan_i_o <= 16'h0000;
         chan_q_o <= 16'h0000;
         chan_valid_o <= 1'b0;
         pwr_i_reg <= 16'h0000;
         pwr_q_reg <= 16'h0000;
         pwr_valid_reg <= 1'b0;
      end else if (ce_i) begin
         chan_valid_o <= pair_fire_w;
         pwr_valid_reg <= pair_fire_w;
         if (pair_fire_w) begin
            chan_i_o <= pair_i_w;
            chan_q_o <= path_reg[`DPCFG_B_IBOTH] ? pair_i_w
                                                 : pair_q_w;
            pwr_i_reg <= pair_i_w;
            pwr_q_reg <= pair_q_w;
         end
      end
   end

   // Mean power measurement
   dpcfg_power_avg #(
      .WIN_BASE_LOG2(WIN_BASE_LOG2)
   ) u_power (
      .clock_i(clock_i),
      .arst_n_i(arst_n_i),
      .ce_i(ce_i),
      .pair_valid_i(pwr_valid_reg),
      .i_i(pwr_i_reg),
      .q_i(pwr_q_reg),
      .swap_i(guard_reg[`DPCFG_B_SWAP]),
      .win_code_i(guard_reg[3:0]),
      .power_o(power_w)
   );

   assign power_hi_w = power_w[12:8];
   assign limit_w = {lim_hi_reg[4:0], lim_lo_reg};

   // Protection flag, held off while the guard is disabled
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         protect_o <= 1'b0;
      end else if (ce_i) begin
         protect_o <= guard_reg[`DPCFG_B_GEN] &&
                      (power_w >= limit_w);
      end
   end

   // Read data; reserved bits and unmapped offsets read zero
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         reg_rdata_o <= 8'h00;
      end else if (ce_i && reg_rd_i) begin
         case (reg_addr_i)
            `DPCFG_A_FIFO: reg_rdata_o <= {6'h00, ack_w, fifo_req_reg};
            `DPCFG_A_FMT: reg_rdata_o <= fmt_reg;
            `DPCFG_A_PATH: reg_rdata_o <= path_reg;
            `DPCFG_A_INTERP: reg_rdata_o <= interp_reg;
            `DPCFG_A_LIM_LO: reg_rdata_o <= lim_lo_reg;
            `DPCFG_A_LIM_HI: reg_rdata_o <= lim_hi_reg;
            `DPCFG_A_GUARD: reg_rdata_o <= guard_reg;
            `DPCFG_A_PWR_LO: reg_rdata_o <= power_w[7:0];
            `DPCFG_A_PWR_HI: reg_rdata_o <= {3'h0, power_hi_w};
            default: reg_rdata_o <= 8'h00;
         endcase
      end
   end

   a_req_starts_reset: assert property (@(posedge clock_i)
      disable iff (!arst_n_i)
      (ce_i && hs_reg == dpcfg_pkg::DPCFG_IDLE && fifo_req_reg)
      |=> fifo_reset_o)
      else $error("FIFO reset did not start on request");

   a_ack_after_done: assert property (@(posedge clock_i)
      disable iff (!arst_n_i)
      $rose(ack_w) |-> $past(fifo_reset_o) && $past(fifo_reset_done_i))
      else $error("acknowledge rose without completed reset");

   a_ack_release: assert property (@(posedge clock_i)
      disable iff (!arst_n_i)
      (ce_i && ack_w && !fifo_req_reg) |=> !ack_w ##1 !fifo_reset_o)
      else $error("acknowledge held after request cleared");

   a_word_format: assert property (@(posedge clock_i)
      disable iff (!arst_n_i)
      (ce_i && sample_valid_i && !fifo_reset_o && !fmt_reg[`DPCFG_B_BYTE])
      |=> word_valid_reg && word_reg == ((fmt_reg[`DPCFG_B_REV] ?
      dpcfg_reverse($past(sample_i)) : $past(sample_i)) ^
      {fmt_reg[`DPCFG_B_BIN], 15'h0000}))
      else $error("word mode sample not formatted");

   a_byte_first_half: assert property (@(posedge clock_i)
      disable iff (!arst_n_i)
      (ce_i && sample_valid_i && !fifo_reset_o && !byte_phase_reg &&
      fmt_reg[`DPCFG_B_BYTE]) |=> !word_valid_reg)
      else $error("byte mode produced a word from one byte");

   a_rate_chain: assert property (@(posedge clock_i)
      disable iff (!arst_n_i)
      (interp_reg[1:0] == 2'b10) |-> halfband_stage_two_o &&
      !halfband_stage_three_o)
      else $error("4x rate did not select two stages");

   a_guard_gate: assert property (@(posedge clock_i)
      disable iff (!arst_n_i)
      (ce_i && !guard_reg[`DPCFG_B_GEN]) |=> !protect_o)
      else $error("protection raised while disabled");

   a_read_high: assert property (@(posedge clock_i)
      disable iff (!arst_n_i)
      (ce_i && reg_rd_i && reg_addr_i == `DPCFG_A_PWR_HI)
      |=> reg_rdata_o == {3'h0, $past(power_hi_w)})
      else $error("power upper bits misread");

   a_inphase_both: assert property (@(posedge clock_i)
      disable iff (!arst_n_i)
      (ce_i && pair_fire_w && path_reg[`DPCFG_B_IBOTH])
      |=> chan_q_o == chan_i_o && pwr_q_reg == $past(pair_q_w))
      else $error("in-phase routing to both channels failed");
endmodule

//--- rtl/dpcfg_cfg.svh
// Purpose: Offsets, field positions, masks and reset values of the bank
// Assumes: Included by bare name from the register bank and its helpers
// Notes: Definitions only
`ifndef DPCFG_CFG_SVH
`define DPCFG_CFG_SVH
// Register offsets
`define DPCFG_A_FIFO 8'h25
`define DPCFG_A_FMT 8'h26
`define DPCFG_A_PATH 8'h27
`define DPCFG_A_INTERP 8'h28
`define DPCFG_A_LIM_LO 8'h29
`define DPCFG_A_LIM_HI 8'h2a
`define DPCFG_A_GUARD 8'h2b
`define DPCFG_A_PWR_LO 8'h2c
`define DPCFG_A_PWR_HI 8'h2d
// Field positions
`define DPCFG_B_REQ 0
`define DPCFG_B_ACK 1
`define DPCFG_B_BIN 7
`define DPCFG_B_PAIR 6
`define DPCFG_B_REV 5
`define DPCFG_B_BYTE 0
`define DPCFG_B_DROOP 7
`define DPCFG_B_NCO 6
`define DPCFG_B_GAIN 5
`define DPCFG_B_PHASE 4
`define DPCFG_B_QMIX 2
`define DPCFG_B_SIDE 1
`define DPCFG_B_IBOTH 0
`define DPCFG_B_GEN 7
`define DPCFG_B_SWAP 6
// Writable bits of each register
`define DPCFG_M_FMT 8'he1
`define DPCFG_M_PATH 8'hf7
`define DPCFG_M_INTERP 8'h03
`define DPCFG_M_LIM_HI 8'h1f
`define DPCFG_M_GUARD 8'hcf
// Reset values
`define DPCFG_R_FIFO 8'h00
`define DPCFG_R_FMT 8'h00
`define DPCFG_R_PATH 8'h00
`define DPCFG_R_INTERP 8'h00
`define DPCFG_R_LIM_LO 8'h00
`define DPCFG_R_LIM_HI 8'h00
`define DPCFG_R_GUARD 8'h00
// Averaging window: base log2 and largest valid code
`define DPCFG_WIN_BASE_LOG2 9
`define DPCFG_WIN_MAX_CODE 4'ha
`endif

//--- rtl/dpcfg_pkg.sv
// Purpose: Types shared by the register bank files
// Assumes: Nothing is imported; users write dpcfg_pkg::name
// Notes: Constants live in dpcfg_cfg.svh
package dpcfg_pkg;
   typedef enum logic [1:0] {
      DPCFG_IDLE = 2'b00,
      DPCFG_RESET = 2'b01,
      DPCFG_ACK = 2'b10
   } dpcfg_hs_t;
   typedef enum logic [1:0] {
      DPCFG_X2 = 2'b00,
      DPCFG_XRSV = 2'b01,
      DPCFG_X4 = 2'b10,
      DPCFG_X8 = 2'b11
   } dpcfg_interp_t;
endpackage

//--- rtl/dpcfg_power_avg.sv
// Purpose: Average of I squared plus Q squared over a sample-pair window
// Assumes: One pair per valid cycle, same clock as the register bank
// Notes: Reading is the top 13 bits of the 32-bit mean
`timescale 1ns/1ps
`include "dpcfg_cfg.svh"
module dpcfg_power_avg #(
   parameter int WIN_BASE_LOG2 = `DPCFG_WIN_BASE_LOG2
) (
   input wire logic clock_i,
   input wire logic arst_n_i,
   input wire logic ce_i,
   input wire logic pair_valid_i,
   input wire logic signed [15:0] i_i,
   input wire logic signed [15:0] q_i,
   input wire logic swap_i,
   input wire logic [3:0] win_code_i,
   output logic [12:0] power_o
);
   localparam int CNT_W = WIN_BASE_LOG2 + 11;
   logic signed [15:0] a_w;
   logic signed [15:0] b_w;
   logic [31:0] sq_w;
   logic [3:0] code_w;
   logic [4:0] shift_w;
   logic [CNT_W-1:0] lim_w;
   logic last_w;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W+31:0] acc_reg;
   logic [CNT_W+31:0] sum_w;
   logic [CNT_W+31:0] mean_w;

   // Channel exchange ahead of the squaring
   assign a_w = swap_i ? q_i : i_i;
   assign b_w = swap_i ? i_i : q_i;
   assign sq_w = 32'(a_w * a_w) + 32'(b_w * b_w);
   // Invalid codes are clamped to the largest window
   assign code_w = (win_code_i > `DPCFG_WIN_MAX_CODE) ?
                   `DPCFG_WIN_MAX_CODE : win_code_i;
   assign shift_w = 5'(WIN_BASE_LOG2) + {1'b0, code_w};
   assign lim_w = CNT_W'((64'd1 << shift_w) - 64'd1);
   assign last_w = cnt_reg >= lim_w;
   assign sum_w = acc_reg + {{CNT_W{1'b0}}, sq_w};
   assign mean_w = sum_w >> shift_w;

   // Accumulate and publish the mean at the end of each window
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_reg <= '0;
         acc_reg <= '0;
         power_o <= 13'h0000;
      end else if (ce_i && pair_valid_i) begin
         if (last_w) begin
            cnt_reg <= '0;
            acc_reg <= '0;
            power_o <= mean_w[31:19];
         end else begin
            cnt_reg <= cnt_reg + 1'b1;
            acc_reg <= sum_w;
         end
      end
   end

   a_power_hold: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      !(ce_i && pair_valid_i && last_w) |=> $stable(power_o))
      else $error("power reading changed outside a window end");
endmodule

//--- verification/dpcfg_tb.sv
// Purpose: Self-checking bench for the datapath configuration registers
// Assumes: Window base shortened to 4 pairs; inputs driven at falling edge
// Notes: Random values from a fixed seed, with hand-picked corner cases
`timescale 1ns/1ps
`include "dpcfg_cfg.svh"
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin err_total++; $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
   logic clock_i, arst_n_i, ce_i, reg_wr_i, reg_rd_i;
   logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, d;
   logic fifo_reset_o, fifo_reset_done_i, sample_valid_i, chan_valid_o;
   logic [15:0] sample_i, chan_i_o, chan_q_o, vi, vq;
   logic droop_o, nco_o, gain_o, phase_o, qmix_o, side_o;
   logic hb1_o, hb2_o, hb3_o, rsv_o, protect_o;
   logic [7:0] addrs [6] = '{8'h26, 8'h27, 8'h28, 8'h29, 8'h2a, 8'h2b};
   logic [7:0] masks [6] = '{`DPCFG_M_FMT, `DPCFG_M_PATH, `DPCFG_M_INTERP,
      8'hff, `DPCFG_M_LIM_HI, `DPCFG_M_GUARD};
   logic [7:0] fmt, path;
   int err_total = 0;
   int checked = 0;
   dpcfg_regs #(.WIN_BASE_LOG2(2)) DUT (.clock_i(clock_i),
      .arst_n_i(arst_n_i), .ce_i(ce_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
      .fifo_reset_o(fifo_reset_o), .fifo_reset_done_i(fifo_reset_done_i),
      .sample_i(sample_i), .sample_valid_i(sample_valid_i),
      .chan_i_o(chan_i_o), .chan_q_o(chan_q_o), .chan_valid_o(chan_valid_o),
      .droop_corrector_on_o(droop_o), .numeric_oscillator_on_o(nco_o),
      .gain_offset_correct_on_o(gain_o), .phase_correct_on_o(phase_o),
      .quarter_rate_mixer_on_o(qmix_o), .image_side_select_o(side_o),
      .halfband_stage_one_o(hb1_o), .halfband_stage_two_o(hb2_o),
      .halfband_stage_three_o(hb3_o), .rate_reserved_o(rsv_o),
      .protect_o(protect_o));
   // Free-running 200 MHz clock
   initial begin
      clock_i = 1'b0;
      forever #2.5 clock_i = ~clock_i;
   end
   // Expected sample after optional reversal and offset-binary conversion
   function automatic logic [15:0] conv(input logic [15:0] r,
      input logic bin, input logic rev);
      logic [15:0] v;
      if (rev) begin
         v = {<<{r}};
      end else begin
         v = r;
      end
      v[15] = v[15] ^ bin;
      return v;
   endfunction
   // Register port strobes, one transfer per call
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge clock_i);
      reg_wr_i = 1'b1;
      reg_addr_i = a;
      reg_wdata_i = v;
      @(negedge clock_i);
      reg_wr_i = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(negedge clock_i);
      reg_rd_i = 1'b1;
      reg_addr_i = a;
      @(negedge clock_i);
      reg_rd_i = 1'b0;
      v = reg_rdata_o;
   endtask
   // Sample stream helpers
   task automatic push(input logic [15:0] v);
      @(negedge clock_i);
      sample_valid_i = 1'b1;
      sample_i = v;
   endtask
   task automatic idle(input int n);
      @(negedge clock_i);
      sample_valid_i = 1'b0;
      repeat (n) @(negedge clock_i);
   endtask
   task automatic wait_pair();
      int k;
      for (k = 0; k < 8 && chan_valid_o !== 1'b1; k++) @(negedge clock_i);
      `CHK(chan_valid_o, 1'b1)
   endtask
   task automatic print_verdict();
      if (err_total == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Watchdog cuts a hang short
   initial begin
      #200000;
      err_total++;
      print_verdict();
   end
   // Main sequence
   initial begin
      arst_n_i = 1'b0; ce_i = 1'b1; reg_wr_i = 1'b0; reg_rd_i = 1'b0;
      reg_addr_i = 8'h00; reg_wdata_i = 8'h00; fifo_reset_done_i = 1'b0;
      sample_i = 16'h0000; sample_valid_i = 1'b0;
      void'($urandom(98));
      repeat (2) @(negedge clock_i);
      arst_n_i = 1'b1;
      // Reset values, read-only and unmapped places
      for (int a = 8'h25; a <= 8'h2d; a++) begin
         rd(a[7:0], d);
         `CHK(d, 8'h00)
      end
      wr(8'h2c, 8'hff);
      rd(8'h2c, d);
      `CHK(d, 8'h00)
      rd(8'h40, d);
      `CHK(d, 8'h00)
      // Random read-write with reserved bits masked
      repeat (4) begin
         for (int i = 0; i < 6; i++) begin
            vi[7:0] = $urandom;
            wr(addrs[i], vi[7:0]);
            rd(addrs[i], d);
            `CHK(d, vi[7:0] & masks[i])
            if (i == 1) begin
               `CHK({droop_o, nco_o, qmix_o}, {vi[7], vi[6], vi[2]})
               `CHK({gain_o, phase_o, side_o}, {vi[5], vi[4], vi[1]})
            end
         end
      end
      // Every rate code
      for (int c = 0; c < 4; c++) begin
         wr(8'h28, c[7:0]);
         `CHK({hb1_o, hb2_o, hb3_o}, {1'b1, c[1], c == 3})
         `CHK(rsv_o, c == 1)
      end
      // Clock enable low freezes the bank: this write must not land
      ce_i = 1'b0;
      wr(8'h28, 8'h00);
      ce_i = 1'b1;
      `CHK(hb3_o, 1'b1)
      // Word mode, pairing with next Q, random format and routing
      wr(8'h2b, 8'h00);
      repeat (6) begin
         fmt = $urandom & 8'ha0;
         path = $urandom & 8'h01;
         vi = $urandom;
         vq = $urandom;
         wr(8'h26, fmt);
         wr(8'h27, path);
         push(vi);
         push(vq);
         idle(0);
         wait_pair();
         `CHK(chan_i_o, conv(vi, fmt[7], fmt[5]))
         `CHK(chan_q_o, conv(path[0] ? vi : vq, fmt[7], fmt[5]))
      end
      // Byte mode, high byte first
      wr(8'h27, 8'h00);
      wr(8'h26, 8'h01);
      vi = $urandom;
      vq = $urandom;
      push({8'h00, vi[15:8]});
      push({8'h00, vi[7:0]});
      push({8'h00, vq[15:8]});
      push({8'h00, vq[7:0]});
      idle(0);
      wait_pair();
      `CHK({chan_i_o, chan_q_o}, {vi, vq})
      // Power over eight pairs closing two 4-pair windows, the first begun by earlier pairs, I and Q swapped in the sum
      wr(8'h26, 8'h00);
      wr(8'h2b, 8'h40);
      repeat (8) begin
         push(16'h4000);
         push(16'hc000);
      end
      idle(10);
      rd(8'h2c, d);
      `CHK(d, 8'h00)
      rd(8'h2d, d);
      `CHK(d, 8'h04)
      wr(8'h29, 8'hff);
      wr(8'h2a, 8'h03);
      idle(3);
      `CHK(protect_o, 1'b0)
      wr(8'h2b, 8'hc0);
      idle(3);
      `CHK(protect_o, 1'b1)
      wr(8'h29, 8'h01);
      wr(8'h2a, 8'h04);
      idle(3);
      `CHK(protect_o, 1'b0)
      wr(8'h29, 8'h00);
      idle(3);
      `CHK(protect_o, 1'b1)
      // FIFO reset four-phase handshake, then pairing with prior Q
      wr(8'h26, 8'h40);
      wr(8'h25, 8'h01);
      idle(2);
      `CHK(fifo_reset_o, 1'b1)
      rd(8'h25, d);
      `CHK(d, 8'h01)
      fifo_reset_done_i = 1'b1;
      @(negedge clock_i);
      fifo_reset_done_i = 1'b0;
      @(negedge clock_i);
      `CHK(fifo_reset_o, 1'b0)
      rd(8'h25, d);
      `CHK(d, 8'h03)
      wr(8'h25, 8'h00);
      idle(2);
      rd(8'h25, d);
      `CHK(d, 8'h00)
      vi = $urandom;
      vq = $urandom;
      push(16'h1234);
      push(vq);
      push(vi);
      idle(0);
      wait_pair();
      `CHK({chan_i_o, chan_q_o}, {vi, vq})
      print_verdict();
   end
endmodule
